// ### lpms_pkg.sv
// Package for the low-power mode sequencer: states, constants and carrier structs
package lpms_pkg;

  // Event line numbering
  localparam int LPMS_NUM_EVT = 32;
  localparam int LPMS_EVT_IO2 = 31;
  localparam int LPMS_EVT_PSD = 16;
  localparam int LPMS_EXT_LINES = 16;

  // Wake-up request sources that may ask for the internal RC oscillator in Stop
  localparam int LPMS_NUM_RCREQ = 4;

  // Regulator settle time before the RC clock is released after a mode change
  localparam int LPMS_REG_SETTLE_NS = 50;
  localparam int LPMS_CLK_NS = 10;
  localparam logic [7:0] LPMS_REG_SETTLE_CYC =
    8'((LPMS_REG_SETTLE_NS + LPMS_CLK_NS - 1) / LPMS_CLK_NS);
  localparam logic [7:0] LPMS_CNT_ZERO = 8'h00;
  localparam logic [7:0] LPMS_CNT_ONE = 8'h01;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    LPMS_ST_RUN     = 6'b00_0001,
    LPMS_ST_SLEEP   = 6'b00_0010,
    LPMS_ST_STOP    = 6'b00_0100,
    LPMS_ST_STANDBY = 6'b00_1000,
    LPMS_ST_REGUP   = 6'b01_0000,
    LPMS_ST_RCON    = 6'b10_0000
  } lpms_state_t;

  // Entry requests from the processor
  typedef struct packed {
    logic sleep;
    logic deep;
    logic standby;
    logic stop_low_power;
  } lpms_req_t;

  // Supply monitor inputs
  typedef struct packed {
    logic main_above_por;
    logic main_above_pdr;
    logic analog_above_pdr;
    logic main_above_psd;
    logic io2_above_ref;
  } lpms_supply_t;

  // Standby exit sources
  typedef struct packed {
    logic external_reset_pin;
    logic independent_watchdog;
    logic wakeup_pin;
    logic rtc_event;
  } lpms_sbwake_t;

  // Power and clock controls
  typedef struct packed {
    logic regulator_on;
    logic regulator_main_mode;
    logic regulator_low_power_mode;
    logic core_clk_en;
    logic periph_clk_en;
    logic pll_en;
    logic internal_rc_oscillator_en;
    logic external_crystal_oscillator_en;
    logic core_domain_powered;
    logic rtc_domain_en;
    logic wdg_domain_en;
    logic lsclk_en;
  } lpms_pwr_t;

endpackage : lpms_pkg

// ### lpms_sequencer.sv
// Low-power mode sequencer: supply supervision, regulator control and Sleep/Stop/Standby
`timescale 1ns/1ps
module lpms_sequencer
  import lpms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Supplies and options
  input wire lpms_supply_t supply,
  input wire logic analog_pdr_disable,
  input wire logic psd_enable,
  input wire logic psd_irq_on_fall,
  input wire logic psd_irq_on_rise,
  // Processor requests and wake-up sources
  input wire lpms_req_t req,
  input wire logic irq_pending,
  input wire logic [LPMS_NUM_EVT-1:0] event_lines,
  input wire logic [LPMS_NUM_RCREQ-1:0] rc_clk_req,
  input wire lpms_sbwake_t sb_wake,
  // Outputs
  output lpms_pwr_t pwr,
  output logic chip_reset,
  output logic psd_irq,
  output logic psd_above,
  output logic io2_pins_disable,
  output logic io2_event,
  output logic rc_clk_grant,
  output lpms_state_t mode
);

  lpms_state_t state, next_state;
  logic [7:0] settle, next_settle;
  logic psd_q, next_psd_q;
  logic wakepin_q, next_wakepin_q;
  logic stop_lp, next_stop_lp;
  logic supply_ok;
  logic stop_wake;
  logic sb_exit;
  logic [LPMS_NUM_EVT-1:0] evt_all;

  // Reset held while any supervised supply is low; no external circuit needed
  assign supply_ok = supply.main_above_por && supply.main_above_pdr &&
                     (analog_pdr_disable || supply.analog_above_pdr);
  assign chip_reset = !supply_ok;

  // Secondary I/O supply comparator
  assign io2_pins_disable = !supply.io2_above_ref;
  assign io2_event = !supply.io2_above_ref;

  // Event lines with the internal sources folded in
  always_comb begin
    evt_all = event_lines;
    evt_all[LPMS_EVT_IO2] = event_lines[LPMS_EVT_IO2] | io2_event;
    evt_all[LPMS_EVT_PSD] = event_lines[LPMS_EVT_PSD] | psd_irq;
  end
  assign stop_wake = |evt_all;
  // Besides a supply reset, only these four sources may end Standby; edge on wake-up pin
  assign sb_exit = sb_wake.external_reset_pin || sb_wake.independent_watchdog ||
                   sb_wake.rtc_event || (sb_wake.wakeup_pin && !wakepin_q);

  // Supply detector crossing logic
  assign psd_above = supply.main_above_psd;
  always_comb begin
    next_psd_q = supply.main_above_psd;
    psd_irq = psd_enable && ((psd_irq_on_fall && psd_q && !supply.main_above_psd) ||
                             (psd_irq_on_rise && !psd_q && supply.main_above_psd));
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_settle = settle;
    next_stop_lp = stop_lp;
    next_wakepin_q = sb_wake.wakeup_pin;
    case (state)
      LPMS_ST_RUN: begin
        // Entry is refused when a wake-up is already waiting, avoiding a needless clock stop
        if (req.deep && req.standby && !sb_exit && !stop_wake) begin
          next_state = LPMS_ST_STANDBY;
        end else if (req.deep && !req.standby && !stop_wake && !irq_pending) begin
          next_state = LPMS_ST_STOP;
          next_stop_lp = req.stop_low_power;
        end else if (req.sleep && !req.deep && !irq_pending && !stop_wake) begin
          next_state = LPMS_ST_SLEEP;
        end
      end
      LPMS_ST_SLEEP: begin
        if (irq_pending || stop_wake) begin
          next_state = LPMS_ST_RUN;
        end
      end
      LPMS_ST_STOP: begin
        if (stop_wake) begin
          next_state = LPMS_ST_RUN;
          next_stop_lp = 1'b0;
        end else if (|rc_clk_req) begin
          next_state = LPMS_ST_REGUP;
          next_settle = stop_lp ? LPMS_REG_SETTLE_CYC : LPMS_CNT_ZERO;
          next_stop_lp = 1'b0;
        end
      end
      LPMS_ST_REGUP: begin
        // Regulator must reach main mode before the RC clock is let out
        if (settle <= LPMS_CNT_ONE) begin
          next_state = LPMS_ST_RCON;
          next_settle = LPMS_CNT_ZERO;
        end else begin
          next_settle = settle - LPMS_CNT_ONE;
        end
      end
      LPMS_ST_RCON: begin
        if (stop_wake) begin
          next_state = LPMS_ST_RUN;
        end else if (!(|rc_clk_req)) begin
          next_state = LPMS_ST_STOP;
        end
      end
      LPMS_ST_STANDBY: begin
        // Exit returns straight to Run without asserting chip_reset; the core domain was unpowered, so contents are gone
        if (sb_exit) begin
          next_state = LPMS_ST_RUN;
        end
      end
      default: next_state = LPMS_ST_RUN;
    endcase
    if (!supply_ok) begin
      next_state = LPMS_ST_RUN;
      next_stop_lp = 1'b0;
      next_settle = LPMS_CNT_ZERO;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= LPMS_ST_RUN;
      settle <= LPMS_CNT_ZERO;
      stop_lp <= 1'b0;
      psd_q <= 1'b1;
      wakepin_q <= 1'b1;
    end else begin
      state <= next_state;
      settle <= next_settle;
      stop_lp <= next_stop_lp;
      psd_q <= next_psd_q;
      wakepin_q <= next_wakepin_q;
    end
  end

  // Power and clock controls, registered
  lpms_pwr_t next_pwr;
  logic next_grant;
  always_comb begin
    next_pwr = '0;
    next_pwr.rtc_domain_en = 1'b1;
    next_pwr.wdg_domain_en = 1'b1;
    next_pwr.lsclk_en = 1'b1;
    next_grant = 1'b0;
    case (next_state)
      LPMS_ST_RUN: begin
        next_pwr.regulator_on = 1'b1;
        next_pwr.regulator_main_mode = 1'b1;
        next_pwr.core_clk_en = 1'b1;
        next_pwr.periph_clk_en = 1'b1;
        next_pwr.pll_en = 1'b1;
        next_pwr.internal_rc_oscillator_en = 1'b1;
        next_pwr.external_crystal_oscillator_en = 1'b1;
        next_pwr.core_domain_powered = 1'b1;
      end
      LPMS_ST_SLEEP: begin
        next_pwr.regulator_on = 1'b1;
        next_pwr.regulator_main_mode = 1'b1;
        next_pwr.periph_clk_en = 1'b1;
        next_pwr.pll_en = 1'b1;
        next_pwr.internal_rc_oscillator_en = 1'b1;
        next_pwr.external_crystal_oscillator_en = 1'b1;
        next_pwr.core_domain_powered = 1'b1;
      end
      LPMS_ST_STOP: begin
        next_pwr.regulator_on = 1'b1;
        next_pwr.regulator_main_mode = !next_stop_lp;
        next_pwr.regulator_low_power_mode = next_stop_lp;
        next_pwr.core_domain_powered = 1'b1;
      end
      LPMS_ST_REGUP: begin
        next_pwr.regulator_on = 1'b1;
        next_pwr.regulator_main_mode = 1'b1;
        next_pwr.core_domain_powered = 1'b1;
      end
      LPMS_ST_RCON: begin
        next_pwr.regulator_on = 1'b1;
        next_pwr.regulator_main_mode = 1'b1;
        next_pwr.core_domain_powered = 1'b1;
        next_pwr.internal_rc_oscillator_en = 1'b1;
        next_grant = 1'b1;
      end
      LPMS_ST_STANDBY: begin
        next_pwr.regulator_on = 1'b0;
      end
      default: next_pwr.regulator_on = 1'b1;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr <= '{regulator_on: 1'b1, regulator_main_mode: 1'b1, core_clk_en: 1'b1,
               periph_clk_en: 1'b1, pll_en: 1'b1, internal_rc_oscillator_en: 1'b1,
               external_crystal_oscillator_en: 1'b1, core_domain_powered: 1'b1,
               rtc_domain_en: 1'b1, wdg_domain_en: 1'b1, lsclk_en: 1'b1,
               default: 1'b0};
      rc_clk_grant <= 1'b0;
    end else begin
      pwr <= next_pwr;
      rc_clk_grant <= next_grant;
    end
  end

  assign mode = state;

endmodule : lpms_sequencer

// ### lpms_chk.sv
// Port checker for the low-power mode sequencer
`timescale 1ns/1ps
module lpms_chk
  import lpms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Inputs
  input wire lpms_supply_t supply,
  input wire logic analog_pdr_disable,
  input wire logic psd_enable,
  input wire logic psd_irq_on_fall,
  input wire logic psd_irq_on_rise,
  input wire lpms_req_t req,
  input wire logic irq_pending,
  input wire logic [LPMS_NUM_EVT-1:0] event_lines,
  input wire logic [LPMS_NUM_RCREQ-1:0] rc_clk_req,
  input wire lpms_sbwake_t sb_wake,
  // Outputs
  input wire lpms_pwr_t pwr,
  input wire logic chip_reset,
  input wire logic psd_irq,
  input wire logic psd_above,
  input wire logic io2_pins_disable,
  input wire logic io2_event,
  input wire logic rc_clk_grant,
  input wire lpms_state_t mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Low-power Stop with a clock request and nothing else pending
  sequence s_lp_rc_req;
    mode == LPMS_ST_STOP && pwr.regulator_low_power_mode && (|rc_clk_req) && !(|event_lines) && !chip_reset;
  endsequence
  sequence s_main_then_grant;
    pwr.regulator_main_mode && !rc_clk_grant ##[1:8] rc_clk_grant;
  endsequence
  a_por_holds_reset: assert property (!supply.main_above_por |-> chip_reset)
    else $error("reset not held on low supply");
  a_psd_fall_irq: assert property (psd_enable && psd_irq_on_fall && $fell(supply.main_above_psd) |-> psd_irq)
    else $error("no detector interrupt on fall");
  a_io2_gates_pins: assert property (io2_pins_disable == !supply.io2_above_ref && io2_event == io2_pins_disable)
    else $error("io2 gating wrong");
  a_sleep_wakes_run: assert property (mode == LPMS_ST_SLEEP && irq_pending |=> mode == LPMS_ST_RUN)
    else $error("sleep not left on interrupt");
  a_psd_rise_irq: assert property (psd_enable && psd_irq_on_rise && $rose(supply.main_above_psd) |-> psd_irq)
    else $error("no detector interrupt on rise");
  a_grant_main_mode: assert property (rc_clk_grant |-> pwr.regulator_main_mode && !pwr.regulator_low_power_mode)
    else $error("rc clock granted in low-power regulator mode");
  a_stop_all_gated: assert property (mode == LPMS_ST_STOP |->
    !pwr.pll_en && !pwr.internal_rc_oscillator_en &&
    !pwr.external_crystal_oscillator_en && !pwr.core_clk_en && pwr.rtc_domain_en && pwr.wdg_domain_en)
    else $error("stop clocks wrong");
  a_stop_event_wake: assert property (mode == LPMS_ST_STOP && (|event_lines) |=> mode == LPMS_ST_RUN)
    else $error("stop not left on event");
  a_rc_after_main: assert property (s_lp_rc_req |=> s_main_then_grant)
    else $error("rc clock before main mode");
  a_standby_all_off: assert property (mode == LPMS_ST_STANDBY |->
    !pwr.regulator_on && !pwr.core_domain_powered &&
    !pwr.pll_en && !pwr.internal_rc_oscillator_en && pwr.rtc_domain_en && pwr.wdg_domain_en && pwr.lsclk_en)
    else $error("standby power wrong");
  a_standby_only_exits: assert property (mode == LPMS_ST_STANDBY && sb_wake == 4'h0 && !chip_reset |=>
    mode == LPMS_ST_STANDBY)
    else $error("standby left without cause");
  a_pending_aborts: assert property (mode == LPMS_ST_RUN && req.deep && (|event_lines) |=>
    mode == LPMS_ST_RUN)
    else $error("entry not aborted");
endmodule : lpms_chk

// ### lpms_core_model.sv
// Processor model that raises an interrupt a set time into Sleep
`timescale 1ns/1ps
module lpms_core_model
  import lpms_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire lpms_state_t mode,
  input wire logic [3:0] wake_delay,
  output logic irq_pending
);
  logic [3:0] cnt;
  // Delayed so a slow wake is exercised; dropped outside Sleep so entry is not refused
  assign irq_pending = (mode == LPMS_ST_SLEEP) && (cnt >= wake_delay);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) cnt <= 4'h0;
    else cnt <= (mode == LPMS_ST_SLEEP) ? cnt + 4'h1 : 4'h0;
  end
endmodule : lpms_core_model

// ### tb_top.sv
// Testbench for the low-power mode sequencer
`timescale 1ns/1ps
module tb_top;
  import lpms_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  lpms_supply_t supply = 5'h1F;
  logic analog_pdr_disable = 1'b0;
  logic psd_enable = 1'b0;
  logic psd_irq_on_fall = 1'b0;
  logic psd_irq_on_rise = 1'b0;
  lpms_req_t req = 4'h0;
  logic irq_pending;
  logic [LPMS_NUM_EVT-1:0] event_lines = '0;
  logic [LPMS_NUM_RCREQ-1:0] rc_clk_req = '0;
  lpms_sbwake_t sb_wake = 4'h0;
  lpms_pwr_t pwr;
  logic chip_reset, psd_irq, psd_above, io2_pins_disable, io2_event, rc_clk_grant;
  lpms_state_t mode;
  int n_mismatch = 0;
  int samples_checked = 0;
  // Rows: supply, analog option, expected reset, expected io2 gating
  logic [7:0] rows [6] = '{8'hF8, 8'h7A, 8'hBA, 8'hDA, 8'hDC, 8'hF1};
  always #5 clk = ~clk;
  lpms_sequencer lpms_sequencer_inst (.clk, .rst, .supply, .analog_pdr_disable, .psd_enable, .psd_irq_on_fall,
    .psd_irq_on_rise, .req, .irq_pending, .event_lines, .rc_clk_req, .sb_wake, .pwr, .chip_reset, .psd_irq,
    .psd_above, .io2_pins_disable, .io2_event, .rc_clk_grant, .mode);
  lpms_core_model lpms_core_model_inst (.clk, .rst, .mode, .wake_delay(4'h3), .irq_pending);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wait_mode(input lpms_state_t m);
    for (int k = 0; k < 20 && mode !== m; k++) tick(1);
  endtask : wait_mode
  task automatic final_report;
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    tick(5);
    rst = 1'b0;
    check(8'(mode), 8'(LPMS_ST_RUN));
    check(8'({pwr.regulator_on, pwr.regulator_main_mode, pwr.regulator_low_power_mode}), 8'h06);
    foreach (rows[i]) begin
      supply = rows[i][7:3];
      analog_pdr_disable = rows[i][2];
      #1;
      check(8'({chip_reset, io2_pins_disable, io2_event}), 8'({rows[i][1], rows[i][0], rows[i][0]}));
      tick(1);
    end
    supply = 5'h1F;
    analog_pdr_disable = 1'b0;
    $display("supply test done");
    tick(1);
    psd_enable = 1'b1;
    psd_irq_on_fall = 1'b1;
    supply.main_above_psd = 1'b0;
    #1 check(8'({psd_irq, psd_above}), 8'h02);
    tick(1);
    psd_irq_on_fall = 1'b0;
    psd_irq_on_rise = 1'b1;
    supply.main_above_psd = 1'b1;
    #1 check(8'({psd_irq, psd_above}), 8'h03);
    tick(1);
    psd_enable = 1'b0;
    $display("detector test done");
    tick(1);
    req.sleep = 1'b1;
    tick(1);
    req.sleep = 1'b0;
    check(8'({mode == LPMS_ST_SLEEP, pwr.core_clk_en, pwr.periph_clk_en}), 8'h05);
    wait_mode(LPMS_ST_RUN);
    check(8'(mode), 8'(LPMS_ST_RUN));
    $display("sleep test done");
    tick(1);
    req = 4'h5;
    tick(1);
    req = 4'h0;
    check(8'({mode == LPMS_ST_STOP, pwr.regulator_low_power_mode, pwr.pll_en, pwr.internal_rc_oscillator_en,
      pwr.external_crystal_oscillator_en, pwr.rtc_domain_en}), 8'h31);
    rc_clk_req = 4'h1;
    for (int k = 0; k < 20 && rc_clk_grant !== 1'b1; k++) tick(1);
    check(8'({rc_clk_grant, pwr.regulator_main_mode, pwr.internal_rc_oscillator_en}), 8'h07);
    rc_clk_req = 4'h0;
    tick(2);
    check(8'(mode), 8'(LPMS_ST_STOP));
    event_lines = 32'h0000_0020;
    tick(1);
    event_lines = '0;
    check(8'(mode), 8'(LPMS_ST_RUN));
    $display("stop test done");
    event_lines = 32'h0000_0008;
    req = 4'h5;
    tick(2);
    check(8'({mode == LPMS_ST_RUN, pwr.pll_en}), 8'h03);
    event_lines = '0;
    req = 4'h6;
    tick(1);
    req = 4'h0;
    check(8'({mode == LPMS_ST_STANDBY, pwr.regulator_on, pwr.core_domain_powered, pwr.pll_en,
      pwr.internal_rc_oscillator_en, pwr.external_crystal_oscillator_en, pwr.rtc_domain_en,
      pwr.wdg_domain_en}), 8'h83);
    event_lines = 32'h0000_0001;
    tick(2);
    event_lines = '0;
    check(8'(mode), 8'(LPMS_ST_STANDBY));
    sb_wake.wakeup_pin = 1'b1;
    wait_mode(LPMS_ST_RUN);
    check(8'(mode), 8'(LPMS_ST_RUN));
    $display("standby test done");
    final_report();
  end
  initial begin
    #20000;
    n_mismatch++;
    final_report();
  end
endmodule : tb_top
bind lpms_sequencer lpms_chk lpms_chk_inst (.clk, .rst, .supply, .analog_pdr_disable, .psd_enable, .psd_irq_on_fall,
  .psd_irq_on_rise, .req, .irq_pending, .event_lines, .rc_clk_req, .sb_wake, .pwr, .chip_reset, .psd_irq,
  .psd_above, .io2_pins_disable, .io2_event, .rc_clk_grant, .mode);
